// [rtl/tcrc_pkg.sv]
// Purpose: constants, register map and carriers for one timer channel
// Assumes: 125 MHz system clock, classic 32-bit wishbone register port
// Notes:   every offset, field position and count lives here, with the reset values of mode, compare, enables and status
package tcrc_pkg;

   // clock rates
   localparam int unsigned CLK_HZ   = 125_000_000;
   localparam int unsigned SLOW_HZ  = 32768;
   // cycles of clk per slow-clock tick, rounded to nearest
   localparam int unsigned SLOW_DIV = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;

   // widths
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADR_W = 8;
   localparam int unsigned DAT_W = 32;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_MODE  = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_CAPT  = 8'h14;
   localparam logic [7:0] OFS_CMP   = 8'h1c;
   localparam logic [7:0] OFS_STAT  = 8'h20;
   localparam logic [7:0] OFS_IEN   = 8'h24;
   localparam logic [7:0] OFS_IDIS  = 8'h28;
   localparam logic [7:0] OFS_IMSK  = 8'h2c;

   // control command bits (write only)
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_DIS_BIT = 1;
   localparam int unsigned CTRL_TRG_BIT = 2;

   // mode fields
   localparam int unsigned MODE_CLK_LSB     = 0;
   localparam int unsigned MODE_CLK_W       = 3;
   localparam int unsigned MODE_RESTART_BIT = 14;
   localparam int unsigned MODE_WAVE_BIT    = 15;
   localparam int unsigned MODE_OUT_A_BIT   = 16;
   localparam int unsigned MODE_OUT_B_BIT   = 17;
   localparam logic [31:0] MODE_USED        = 32'h0003_c007;

   // status bits; the low byte is sticky and cleared by a read
   localparam int unsigned STAT_OVF_BIT   = 0;
   localparam int unsigned STAT_CAPT_BIT  = 2;
   localparam int unsigned STAT_MATCH_BIT = 4;
   localparam int unsigned STAT_RUN_BIT   = 16;
   localparam logic [7:0]  STAT_SRC_MASK  = 8'h15;

   // reset values
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [15:0] CMP_RST  = 16'h0000;
   localparam logic [7:0]  IEN_RST  = 8'h00;
   localparam logic [7:0]  STAT_RST = 8'h00;

   // input clock choices
   typedef enum logic [2:0] {
      CLK_DIV2    = 3'h0,
      CLK_DIV8    = 3'h1,
      CLK_DIV128  = 3'h2,
      CLK_DIV1024 = 3'h3,
      CLK_SLOW    = 3'h4
   } tcrc_clksel_t;

   // prescaler taps: log2 of each division
   localparam int unsigned LOG_DIV2    = 1;
   localparam int unsigned LOG_DIV8    = 3;
   localparam int unsigned LOG_DIV128  = 7;
   localparam int unsigned LOG_DIV1024 = 10;
   localparam int unsigned NUM_TICKS   = 5;

   // channel run state
   typedef enum logic {
      ST_OFF = 1'b0,
      ST_RUN = 1'b1
   } tcrc_state_t;

   // wishbone carriers
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [7:0]       adr;
      logic [3:0]       sel;
      logic [31:0]      dat;
   } tcrc_wb_req_t;

   typedef struct packed {
      logic             ack;
      logic [31:0]      dat;
   } tcrc_wb_rsp_t;

endpackage

// [rtl/tcrc_prescaler.sv]
// Purpose: one-cycle tick enables for each selectable channel input clock
// Assumes: single clock domain, synchronous active-high reset
// Notes:   binary taps share one free-running counter so they stay aligned; the slow tick has its own counter
`timescale 1ns/10ps
`default_nettype none
module tcrc_prescaler #(
   parameter int unsigned SLOW_DIV = tcrc_pkg::SLOW_DIV
) (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // tick enables, one bit per clock choice
   output logic [tcrc_pkg::NUM_TICKS-1:0]      tick
);

   localparam int unsigned SW = $clog2(SLOW_DIV);

   if (SLOW_DIV < 2) begin : g_chk
      $error("tcrc_prescaler: SLOW_DIV must be at least 2");
   end

   logic [9:0]                     div_q, div_d;
   logic [SW-1:0]                  slow_q, slow_d;
   logic [tcrc_pkg::NUM_TICKS-1:0] tick_q, tick_d;

   // a binary tap fires when its low counter bits are all ones, the slow tap at SLOW_DIV - 1
   always_comb begin
      div_d  = div_q + 10'h001;
      slow_d = (slow_q == SW'(SLOW_DIV - 1)) ? '0 : slow_q + SW'(1);
      tick_d[tcrc_pkg::CLK_DIV2]    = &div_q[tcrc_pkg::LOG_DIV2-1:0];
      tick_d[tcrc_pkg::CLK_DIV8]    = &div_q[tcrc_pkg::LOG_DIV8-1:0];
      tick_d[tcrc_pkg::CLK_DIV128]  = &div_q[tcrc_pkg::LOG_DIV128-1:0];
      tick_d[tcrc_pkg::CLK_DIV1024] = &div_q[tcrc_pkg::LOG_DIV1024-1:0];
      tick_d[tcrc_pkg::CLK_SLOW]    = (slow_q == SW'(SLOW_DIV - 1));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q  <= '0;
         slow_q <= '0;
         tick_q <= '0;
      end else begin
         div_q  <= div_d;
         slow_q <= slow_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule
`default_nettype wire

// [rtl/tcrc_channel.sv]
// Purpose: one 16-bit timer channel with compare restart and capture
// Assumes: classic wishbone slave, inputs synchronous to clk
// Notes:   the slow clock is derived from clk, so it is an enable only;
//          the prescaler free-runs, so the first tick after an enable
//          may come early by up to one input period;
//          a status read clears the flags at the edge that latches the
//          read data, and an event landing in that edge is kept
//
// Summary of operation
// - clock disable command stops counting until re-enabled
// - capture mode measures incoming signal edges
// - waveform mode generates output pulses
// - compare tick can drive either waveform pin
// - restart bit resets counter on compare match
// - counter and compare value are 16 bits
// - input clock from master clock divided 2..1024
// - slow 32768 Hz clock also selectable
// - compare interrupt when its enable bit set
// - interrupt stays until software acknowledges
// - status read acknowledges and clears latched flags
`timescale 1ns/10ps
`default_nettype none
module tcrc_channel #(
   parameter int unsigned CNT_W    = tcrc_pkg::CNT_W,
   parameter int unsigned SLOW_DIV = tcrc_pkg::SLOW_DIV
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // wishbone register port
   input  wire tcrc_pkg::tcrc_wb_req_t wb_req,
   output var  tcrc_pkg::tcrc_wb_rsp_t wb_rsp,
   // signal to be measured in capture mode
   input  wire logic                   capture_in,
   // waveform pins and interrupt
   output logic                        waveform_output_a,
   output logic                        waveform_output_b,
   output logic                        irq
);

   if (CNT_W < 2 || CNT_W > 32) begin : g_chk
      $error("tcrc_channel: CNT_W must lie in 2..32");
   end

   if (SLOW_DIV < 2) begin : g_chk_div
      $error("tcrc_channel: SLOW_DIV must be at least 2");
   end

   // merge a bus write into a word under its byte enables
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // pick the tick enable of the selected input clock
   function automatic logic pick_tick(
      input logic [tcrc_pkg::NUM_TICKS-1:0] t,
      input logic [2:0]                     s);
      logic r;
      r = 1'b0;
      case (s)
         tcrc_pkg::CLK_DIV2:    r = t[tcrc_pkg::CLK_DIV2];
         tcrc_pkg::CLK_DIV8:    r = t[tcrc_pkg::CLK_DIV8];
         tcrc_pkg::CLK_DIV128:  r = t[tcrc_pkg::CLK_DIV128];
         tcrc_pkg::CLK_DIV1024: r = t[tcrc_pkg::CLK_DIV1024];
         tcrc_pkg::CLK_SLOW:    r = t[tcrc_pkg::CLK_SLOW];
         default:               r = 1'b0;
      endcase
      return r;
   endfunction

   // prescaler taps
   logic [tcrc_pkg::NUM_TICKS-1:0] ticks;

   tcrc_prescaler #(
      .SLOW_DIV (SLOW_DIV)
   ) u_presc (
      .clk  (clk),
      .rst  (rst),
      .tick (ticks)
   );

   // register state
   tcrc_pkg::tcrc_state_t  st_q, st_d;
   tcrc_pkg::tcrc_wb_rsp_t rsp_q, rsp_d;
   logic [31:0]            mode_q, mode_d;
   logic [CNT_W-1:0]       cmp_q, cmp_d;
   logic [CNT_W-1:0]       cnt_q, cnt_d;
   logic [CNT_W-1:0]       capt_q, capt_d;
   logic [7:0]             stat_q, stat_d;
   logic [7:0]             ien_q, ien_d;
   logic                   cap_prev_q, cap_prev_d;
   logic                   wave_q, wave_d;
   logic                   out_a_q, out_a_d;
   logic                   out_b_q, out_b_d;
   logic                   irq_q, irq_d;

   // bus decode and channel events
   logic             acc;
   logic             take;
   logic             wr;
   logic             rd_first;
   logic             running;
   logic             tick;
   logic             match;
   logic             restart;
   logic             wave_mode;
   logic             cap_edge;
   logic             ovf;
   logic             sw_trg;
   logic [7:0]       stat_set;
   logic [7:0]       stat_clr;
   logic [31:0]      rd_val;
   logic [31:0]      ctrl_w;

   // bus decode: writes land on the edge the master samples ack
   always_comb begin
      acc      = wb_req.cyc & wb_req.stb;
      take     = acc & rsp_q.ack;
      wr       = take & wb_req.we;
      rd_first = acc & ~rsp_q.ack & ~wb_req.we;
      ctrl_w   = merge_sel(32'h0000_0000, wb_req.dat, wb_req.sel);
   end

   // read mux; unmapped offsets and write-only ones read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (wb_req.adr)
         tcrc_pkg::OFS_MODE:  rd_val = mode_q;
         tcrc_pkg::OFS_COUNT: rd_val = 32'(cnt_q);
         tcrc_pkg::OFS_CAPT:  rd_val = 32'(capt_q);
         tcrc_pkg::OFS_CMP:   rd_val = 32'(cmp_q);
         tcrc_pkg::OFS_STAT: begin
            // the running bit is live, not sticky
            rd_val = {24'h00_0000, stat_q};
            rd_val[tcrc_pkg::STAT_RUN_BIT] = (st_q == tcrc_pkg::ST_RUN);
         end
         tcrc_pkg::OFS_IMSK:  rd_val = {24'h00_0000, ien_q};
         default:             rd_val = 32'h0000_0000;
      endcase
   end

   // bus answer: ack one cycle after the request, dropped right after
   always_comb begin
      // ack never stands two cycles, so a held request is taken again every second cycle
      rsp_d.ack = acc & ~rsp_q.ack;
      rsp_d.dat = rsp_q.dat;
      if (rd_first) begin
         rsp_d.dat = rd_val;
      end
   end

   // mode, compare and interrupt enable registers
   always_comb begin
      mode_d = mode_q;
      cmp_d  = cmp_q;
      ien_d  = ien_q;
      if (wr) begin
         case (wb_req.adr)
            tcrc_pkg::OFS_MODE:
               mode_d = merge_sel(mode_q, wb_req.dat, wb_req.sel)
                        & tcrc_pkg::MODE_USED;
            tcrc_pkg::OFS_CMP:
               cmp_d = CNT_W'(merge_sel(32'(cmp_q), wb_req.dat,
                                        wb_req.sel));
            tcrc_pkg::OFS_IEN:
               ien_d = ien_q | (ctrl_w[7:0] & tcrc_pkg::STAT_SRC_MASK);
            tcrc_pkg::OFS_IDIS:
               ien_d = ien_q & ~ctrl_w[7:0];
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
   end

   // run state: disable wins over a simultaneous enable
   always_comb begin
      st_d   = st_q;
      sw_trg = 1'b0;
      if (wr && wb_req.adr == tcrc_pkg::OFS_CTRL) begin
         // an enable while running changes nothing; a trigger restarts
         sw_trg = ctrl_w[tcrc_pkg::CTRL_TRG_BIT];
         case (st_q)
            tcrc_pkg::ST_OFF:
               if (ctrl_w[tcrc_pkg::CTRL_EN_BIT] &&
                   !ctrl_w[tcrc_pkg::CTRL_DIS_BIT]) begin
                  st_d = tcrc_pkg::ST_RUN;
               end
            tcrc_pkg::ST_RUN:
               if (ctrl_w[tcrc_pkg::CTRL_DIS_BIT]) begin
                  st_d = tcrc_pkg::ST_OFF;
               end
            default: st_d = tcrc_pkg::ST_OFF;
         endcase
      end
   end

   // counter: the compare value holds for one input period, then restarts
   always_comb begin
      running   = (st_q == tcrc_pkg::ST_RUN);
      wave_mode = mode_q[tcrc_pkg::MODE_WAVE_BIT];
      restart   = mode_q[tcrc_pkg::MODE_RESTART_BIT];
      tick      = pick_tick(ticks,
                     mode_q[tcrc_pkg::MODE_CLK_LSB +: tcrc_pkg::MODE_CLK_W]);
      match     = running & tick & (cnt_q == cmp_q);
      ovf       = running & tick & (&cnt_q) & ~(match & restart);
      cnt_d     = cnt_q;
      // a trigger beats a tick so the new period starts at zero
      if (sw_trg) begin
         cnt_d = '0;
      end else if (running && tick) begin
         if (match && restart) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   // capture: rising edge of the input latches the count
   always_comb begin
      // previous level resets low, the idle level, so no false edge
      cap_prev_d = capture_in;
      cap_edge   = running & ~wave_mode & capture_in & ~cap_prev_q;
      capt_d     = cap_edge ? cnt_q : capt_q;
   end

   // waveform: each compare match toggles the selected pins
   always_comb begin
      wave_d  = (wave_mode && match) ? ~wave_q : wave_q;
      out_a_d = wave_mode & mode_q[tcrc_pkg::MODE_OUT_A_BIT] & wave_d;
      out_b_d = wave_mode & mode_q[tcrc_pkg::MODE_OUT_B_BIT] & wave_d;
   end

   // sticky status: a new event beats a clearing read in the same cycle
   always_comb begin
      stat_set = 8'h00;
      stat_set[tcrc_pkg::STAT_MATCH_BIT] = match;
      stat_set[tcrc_pkg::STAT_CAPT_BIT]  = cap_edge;
      stat_set[tcrc_pkg::STAT_OVF_BIT]   = ovf;
      stat_clr = (rd_first && wb_req.adr == tcrc_pkg::OFS_STAT)
                 ? 8'hff : 8'h00;
      stat_d   = (stat_q & ~stat_clr) | stat_set;
      // irq follows the next status, so it rises with the flag itself
      irq_d    = |(stat_d & ien_d);
   end

   // state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q       <= tcrc_pkg::ST_OFF;
         rsp_q      <= '0;
         mode_q     <= tcrc_pkg::MODE_RST;
         cmp_q      <= CNT_W'(tcrc_pkg::CMP_RST);
         cnt_q      <= '0;
         capt_q     <= '0;
         stat_q     <= tcrc_pkg::STAT_RST;
         ien_q      <= tcrc_pkg::IEN_RST;
         cap_prev_q <= 1'b0;
         wave_q     <= 1'b0;
         out_a_q    <= 1'b0;
         out_b_q    <= 1'b0;
         irq_q      <= 1'b0;
      end else begin
         st_q       <= st_d;
         rsp_q      <= rsp_d;
         mode_q     <= mode_d;
         cmp_q      <= cmp_d;
         cnt_q      <= cnt_d;
         capt_q     <= capt_d;
         stat_q     <= stat_d;
         ien_q      <= ien_d;
         cap_prev_q <= cap_prev_d;
         wave_q     <= wave_d;
         out_a_q    <= out_a_d;
         out_b_q    <= out_b_d;
         irq_q      <= irq_d;
      end
   end

   // outputs straight from flops
   assign wb_rsp            = rsp_q;
   assign waveform_output_a = out_a_q;
   assign waveform_output_b = out_b_q;
   assign irq               = irq_q;

endmodule
`default_nettype wire

// [bench/tcrc_channel_monitor.sv]
// Purpose: port checks for one timer channel
// Assumes: the bus master holds each request until it sees ack
// Notes:   shadows of mode, compare and enables follow landed writes
`timescale 1ns/10ps
`default_nettype none
module tcrc_channel_monitor #(
   parameter int unsigned CNT_W    = tcrc_pkg::CNT_W,
   parameter int unsigned SLOW_DIV = tcrc_pkg::SLOW_DIV
) (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // register port
   input wire tcrc_pkg::tcrc_wb_req_t wb_req,
   input wire tcrc_pkg::tcrc_wb_rsp_t wb_rsp,
   // pins and interrupt
   input wire logic                   capture_in,
   input wire logic                   waveform_output_a,
   input wire logic                   waveform_output_b,
   input wire logic                   irq
);
   logic        req, wr, rd, touch;
   logic [31:0] m, mode_q, mode_d;
   logic [15:0] cmp_q, cmp_d;
   logic [7:0]  ien_q, ien_d;
   logic        run_q, run_d, capf_q, capf_d, cprev_q;

   // shadow next values; a write lands at the edge that sees ack
   always_comb begin
      req   = wb_req.cyc && wb_req.stb;
      wr    = req && wb_req.we && wb_rsp.ack;
      rd    = req && !wb_req.we && wb_rsp.ack;
      touch = req && (wb_req.we ? wb_req.adr == tcrc_pkg::OFS_IDIS
                                : wb_req.adr == tcrc_pkg::OFS_STAT);
      for (int i = 0; i < 32; i++)
         m[i] = wb_req.sel[i / 8];
      mode_d = mode_q;
      cmp_d  = cmp_q;
      ien_d  = ien_q;
      if (wr && wb_req.adr == tcrc_pkg::OFS_MODE)
         mode_d = (mode_q & ~m | wb_req.dat & m) & tcrc_pkg::MODE_USED;
      if (wr && wb_req.adr == tcrc_pkg::OFS_CMP)
         cmp_d = cmp_q & ~m[15:0] | wb_req.dat[15:0] & m[15:0];
      if (wr && wb_req.sel[0] && wb_req.adr == tcrc_pkg::OFS_IEN)
         ien_d = ien_q | wb_req.dat[7:0] & tcrc_pkg::STAT_SRC_MASK;
      if (wr && wb_req.sel[0] && wb_req.adr == tcrc_pkg::OFS_IDIS)
         ien_d = ien_q & ~wb_req.dat[7:0];
      // run state and capture flag, as a status read should show them
      run_d = run_q;
      if (wr && wb_req.sel[0] && wb_req.adr == tcrc_pkg::OFS_CTRL)
         run_d = wb_req.dat[1] ? 1'b0 : wb_req.dat[0] ? 1'b1 : run_q;
      capf_d = capf_q;
      if (touch && !wb_req.we && !wb_rsp.ack)
         capf_d = 1'b0;
      if (run_q && !mode_q[15] && capture_in && !cprev_q)
         capf_d = 1'b1;
   end

   // shadow registers
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= tcrc_pkg::MODE_RST;
         cmp_q  <= tcrc_pkg::CMP_RST;
         ien_q  <= tcrc_pkg::IEN_RST;
         run_q  <= 1'b0;
         capf_q <= 1'b0;
         cprev_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         cmp_q  <= cmp_d;
         ien_q  <= ien_d;
         run_q  <= run_d;
         capf_q <= capf_d;
         cprev_q <= capture_in;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_take; req && !wb_rsp.ack; endsequence
   sequence s_answer; wb_rsp.ack ##1 !wb_rsp.ack; endsequence
   property p_ack; s_take |=> s_answer; endproperty
   a_ack: assert property (p_ack)
      else $error("ack is not a single pulse one cycle after request");
   property p_mode; rd && wb_req.adr == tcrc_pkg::OFS_MODE
      |-> wb_rsp.dat == mode_q; endproperty
   a_mode: assert property (p_mode)
      else $error("mode read differs from written value");
   property p_cmp; rd && wb_req.adr == tcrc_pkg::OFS_CMP
      |-> wb_rsp.dat == {16'h0000, cmp_q}; endproperty
   a_cmp: assert property (p_cmp)
      else $error("compare read differs from written value");
   property p_imsk; rd && wb_req.adr == tcrc_pkg::OFS_IMSK
      |-> wb_rsp.dat == {24'h000000, ien_q}; endproperty
   a_imsk: assert property (p_imsk)
      else $error("enable mask read differs from set and clear writes");
   // pins may lag the mode write by one registered cycle
   property p_quiet; !mode_q[15] && !$past(mode_q[15])
      |-> !waveform_output_a && !waveform_output_b; endproperty
   a_quiet: assert property (p_quiet)
      else $error("waveform pin active outside waveform mode");
   property p_pin_a; $rose(waveform_output_a)
      |-> $past(mode_q[15] && mode_q[16]); endproperty
   a_pin_a: assert property (p_pin_a)
      else $error("pin a rose while not selected");
   property p_irq_en; irq |-> ien_q != 8'h00 || $past(ien_q) != 8'h00;
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("interrupt raised with no source enabled");
   property p_irq_hold; $fell(irq) |-> $past(touch) || $past(touch, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without status read or disable");
   property p_run; rd && wb_req.adr == tcrc_pkg::OFS_STAT
      |-> wb_rsp.dat[16] == $past(run_q); endproperty
   a_run: assert property (p_run)
      else $error("running bit differs from enable and disable writes");
   property p_capt; rd && wb_req.adr == tcrc_pkg::OFS_STAT
      |-> wb_rsp.dat[2] == $past(capf_q); endproperty
   a_capt: assert property (p_capt)
      else $error("capture flag differs from input edges seen");
   property p_pin_b; $rose(waveform_output_b)
      |-> $past(mode_q[15] && mode_q[17]); endproperty
   a_pin_b: assert property (p_pin_b)
      else $error("pin b rose while not selected");
endmodule

bind tcrc_channel tcrc_channel_monitor #(
   .CNT_W(CNT_W), .SLOW_DIV(SLOW_DIV)
) u_tcrc_channel_monitor (
   .clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .capture_in(capture_in), .waveform_output_a(waveform_output_a),
   .waveform_output_b(waveform_output_b), .irq(irq));
`default_nettype wire

// [bench/test_tcrc_channel.sv]
// Purpose: self-checking bench for one timer channel
// Assumes: slow clock shortened to SDIV cycles a tick
// Notes:   reads sit whole ticks apart, so prescaler phase cannot matter
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   fails++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_tcrc_channel;
   localparam int unsigned SDIV = 20;
   logic                   clk, rst, cap, pa, pb, irq, lv;
   tcrc_pkg::tcrc_wb_req_t req;
   tcrc_pkg::tcrc_wb_rsp_t rsp;
   int                     fails, checked, n, m;
   logic [31:0]            d, e, c1;
   logic [7:0]             ofs [6] = '{tcrc_pkg::OFS_MODE, 8'h08,
      tcrc_pkg::OFS_COUNT, tcrc_pkg::OFS_CMP, tcrc_pkg::OFS_STAT,
      tcrc_pkg::OFS_IMSK};

   tcrc_channel #(.SLOW_DIV(SDIV)) u_tcrc_channel (
      .clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .capture_in(cap),
      .waveform_output_a(pa), .waveform_output_b(pb), .irq(irq));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // one classic cycle; always three edges, so read spacing is known
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      int k;
      @(posedge clk);
      req <= {1'b1, 1'b1, we, a, 4'hf, wd};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         fails++;
         print_verdict();
      end
      rd = rsp.dat;
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v, d);
   endtask
   task automatic rdr(input logic [7:0] a);
      bus(1'b0, a, 32'h0, d);
   endtask

   // input clock period in clk cycles per selection
   function automatic int per(input int s);
      return s == 0 ? 2 : s == 1 ? 8 : s == 2 ? 128 : s == 3 ? 1024 : SDIV;
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      print_verdict();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      cap = 1'b0;
      fails = 0;
      checked = 0;
      void'($urandom(79292));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (ofs[i]) begin
         rdr(ofs[i]);
         `CHK("reset value", 32'h0, d)
      end
      repeat (6) begin
         e = $urandom();
         wr(tcrc_pkg::OFS_MODE, e);
         rdr(tcrc_pkg::OFS_MODE);
         `CHK("mode", e & tcrc_pkg::MODE_USED, d)
         wr(tcrc_pkg::OFS_CMP, e | 32'hffff * (e[0]));
         rdr(tcrc_pkg::OFS_CMP);
         `CHK("compare", {16'h0, e[0] ? 16'hffff : e[15:0]}, d)
      end
      // each input clock, restart off, whole ticks between latches
      for (int s = 0; s < 6; s++) begin
         wr(tcrc_pkg::OFS_MODE, s);
         wr(tcrc_pkg::OFS_CTRL, 32'h5);
         m = per(s) >= 40 ? 1 : 40 / per(s);
         n = s < 5 ? m : 0;     // selection 5 gives no ticks at all
         rdr(tcrc_pkg::OFS_COUNT);
         c1 = d;
         repeat (m * per(s) - 3) @(posedge clk);
         rdr(tcrc_pkg::OFS_COUNT);
         `CHK("ticks", (c1 + n) & 32'hffff, d)
      end
      // disable freezes the count, enable resumes it
      wr(tcrc_pkg::OFS_MODE, 32'h0);
      wr(tcrc_pkg::OFS_CTRL, 32'h2);
      rdr(tcrc_pkg::OFS_COUNT);
      c1 = d;
      repeat (50) @(posedge clk);
      rdr(tcrc_pkg::OFS_COUNT);
      `CHK("frozen", c1, d)
      rdr(tcrc_pkg::OFS_STAT);
      `CHK("running", 1'b0, d[16])
      wr(tcrc_pkg::OFS_CTRL, 32'h1);
      repeat (37) @(posedge clk);
      rdr(tcrc_pkg::OFS_COUNT);
      `CHK("resumed", 1'b1, d != c1)
      // restart on match: count repeats every compare+1 ticks
      e = 3 + $urandom_range(6);
      wr(tcrc_pkg::OFS_CMP, e);
      wr(tcrc_pkg::OFS_MODE, 32'h4000);
      wr(tcrc_pkg::OFS_CTRL, 32'h5);
      repeat (6) begin
         repeat ($urandom_range(5)) @(posedge clk);
         rdr(tcrc_pkg::OFS_COUNT);
         `CHK("bounded", 1'b1, d <= e)
      end
      c1 = d;
      repeat ((e + 1) * 6 - 3) @(posedge clk);
      rdr(tcrc_pkg::OFS_COUNT);
      `CHK("period", c1, d)
      rdr(tcrc_pkg::OFS_STAT);
      `CHK("match flag", 1'b1, d[4])
      `CHK("irq masked", 1'b0, irq)
      wr(tcrc_pkg::OFS_IEN, 32'h10);
      rdr(tcrc_pkg::OFS_IMSK);
      `CHK("enables", 32'h10, d)
      repeat (2 * e + 4) @(posedge clk);
      `CHK("irq on", 1'b1, irq)
      wr(tcrc_pkg::OFS_CTRL, 32'h2);    // freeze so no new match
      repeat (60) @(posedge clk);
      `CHK("irq held", 1'b1, irq)
      rdr(tcrc_pkg::OFS_STAT);
      @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      rdr(tcrc_pkg::OFS_STAT);
      `CHK("flag cleared", 1'b0, d[4])
      wr(tcrc_pkg::OFS_IDIS, 32'h10);
      // selected pin toggles each 8-cycle period, the other stays low
      wr(tcrc_pkg::OFS_CMP, 32'h3);
      for (int p = 0; p < 2; p++) begin
         wr(tcrc_pkg::OFS_MODE, 32'hc000 | (32'h10000 << p));
         wr(tcrc_pkg::OFS_CTRL, 32'h5);
         n = 0;
         m = 0;
         lv = p ? pb : pa;
         repeat (80) begin
            @(posedge clk);
            n += ((p ? pb : pa) !== lv);
            lv = p ? pb : pa;
            m += ((p ? pa : pb) !== 1'b0);
         end
         `CHK("toggles", 1'b1, n >= 9 && n <= 11)
         `CHK("other pin", 0, m)
      end
      // capture mode: a rising input latches the running count
      wr(tcrc_pkg::OFS_MODE, 32'h3);
      wr(tcrc_pkg::OFS_CTRL, 32'h5);
      rdr(tcrc_pkg::OFS_STAT);
      repeat ($urandom_range(3000)) @(posedge clk);
      rdr(tcrc_pkg::OFS_COUNT);
      c1 = d;
      cap <= 1'b1;
      repeat (1 + $urandom_range(3)) @(posedge clk);
      cap <= 1'b0;
      rdr(tcrc_pkg::OFS_COUNT);
      e = d;
      rdr(tcrc_pkg::OFS_CAPT);
      `CHK("capture", 1'b1, d == c1 || d == e)
      rdr(tcrc_pkg::OFS_STAT);
      `CHK("capture flag", 1'b1, d[2])
      print_verdict();
   end
endmodule
`default_nettype wire
